/* File: logic/csfr_pkg.sv */
// constants and carrier types for the core sfr bank and port map
package csfr_pkg;

    typedef logic [7:0] csfr_byte_t;

    // register offsets in the direct-addressed sfr space
    localparam csfr_byte_t A_P0    = 8'h80;
    localparam csfr_byte_t A_SP    = 8'h81;
    localparam csfr_byte_t A_DPL   = 8'h82;
    localparam csfr_byte_t A_DPH   = 8'h83;
    localparam csfr_byte_t A_POWER_CONTROL  = 8'h87;
    localparam csfr_byte_t A_TIMER_CONTROL  = 8'h88;
    localparam csfr_byte_t A_TIMER_MODE  = 8'h89;
    localparam csfr_byte_t A_TL0   = 8'h8a;
    localparam csfr_byte_t A_TL1   = 8'h8b;
    localparam csfr_byte_t A_TH0   = 8'h8c;
    localparam csfr_byte_t A_TH1   = 8'h8d;
    localparam csfr_byte_t A_P1    = 8'h90;
    localparam csfr_byte_t A_SERIAL_CONTROL  = 8'h98;
    localparam csfr_byte_t A_SERIAL_BUFFER  = 8'h99;
    localparam csfr_byte_t A_P2    = 8'ha0;
    localparam csfr_byte_t A_IEL   = 8'ha8;
    localparam csfr_byte_t A_P3    = 8'hb0;
    localparam csfr_byte_t A_IPL   = 8'hb8;
    localparam csfr_byte_t A_PSW   = 8'hd0;
    localparam csfr_byte_t A_ACC   = 8'he0;
    localparam csfr_byte_t A_IEH   = 8'he8;
    localparam csfr_byte_t A_B     = 8'hf0;
    localparam csfr_byte_t A_IPH   = 8'hf8;
    localparam csfr_byte_t A_EVST  = 8'hc0;
    localparam csfr_byte_t A_EVMSK = 8'hc1;

    // plain storage registers, no side effects
    localparam int         PL_N    = 14;
    localparam int         PL_TIMER_MODE = 4;
    localparam csfr_byte_t PLAIN_ADDR [PL_N] = '{A_SP, A_DPL, A_DPH, A_POWER_CONTROL, A_TIMER_MODE, A_SERIAL_CONTROL, A_SERIAL_BUFFER,
                                                 A_IEL, A_IPL, A_PSW, A_ACC, A_IEH, A_B, A_IPH};
    localparam csfr_byte_t TL_ADDR [2] = '{A_TL0, A_TL1};
    localparam csfr_byte_t TH_ADDR [2] = '{A_TH0, A_TH1};

    // reset values
    localparam csfr_byte_t RST_PORT = 8'hff;
    localparam csfr_byte_t RST_SFR  = 8'h00;

    // timer control and mode fields
    localparam int TC_IT0 = 0;
    localparam int TC_IE0 = 1;
    localparam int TC_IT1 = 2;
    localparam int TC_IE1 = 3;
    localparam int TC_TR [2] = '{4, 6};
    localparam int TC_TF [2] = '{5, 7};
    localparam int TM_CNT [2] = '{2, 6};
    localparam int TM_GATE [2] = '{3, 7};

    // port bit assignment
    localparam int P2_LSA   = 0;
    localparam int P2_LSB   = 1;
    localparam int P2_LINTX = 3;
    localparam int P3_URX   = 0;
    localparam int P3_UTX   = 1;
    localparam int P3_INT0  = 2;
    localparam int P3_INT1  = 3;
    localparam int P3_T0    = 4;
    localparam int P3_T1    = 5;
    localparam int P3_WDOG  = 7;

    // synchroniser lanes
    localparam int SY_W    = 12;
    localparam int SY_LIN  = 0;
    localparam int SY_GP1  = 1;
    localparam int SY_GP2  = 2;
    localparam int SY_URX  = 3;
    localparam int SY_P1LO = 4;

    // event status bits
    localparam int EV_W    = 5;
    localparam int EV_INT0 = 0;
    localparam int EV_INT1 = 1;
    localparam int EV_TF0  = 2;
    localparam int EV_TF1  = 3;
    localparam int EV_WDOG = 4;

    // absolute jump and call opcode low fields
    localparam logic [4:0] OPC_AJMP  = 5'h01;
    localparam logic [4:0] OPC_ACALL = 5'h11;

    typedef enum logic [1:0] {ACC_FETCH, ACC_CALIB, ACC_VAR} csfr_acc_t;
    typedef enum logic [1:0] {MEM_NONE, MEM_OTP, MEM_EEPROM, MEM_SRAM} csfr_mem_t;

    typedef struct packed {
        logic      valid;
        csfr_acc_t kind;
    } csfr_memreq_t;

    typedef struct packed {
        logic        valid;
        logic        reg_grp;
        logic [2:0]  reg_sel;
        logic        is_abs;
        logic        is_call;
        logic [10:0] abs_dest;
    } csfr_dec_t;

endpackage : csfr_pkg

/* File: logic/csfr_top.sv */
// core sfr bank, port map, opcode field decode and memory steering
// Notes on behaviour
// - opcodes in a block of eight pick working register 0..7 from their three low bits.
// - absolute jump and call opcodes carry destination bits 10..8 in their three high bits.
// - four 8-bit ports are sfr registers that power up as all ones.
// - port 3 bit 2 is the lin receive line and the active-low external interrupt 0.
// - port 3 bit 3 is the inverted lin receive line and the active-low external interrupt 1.
// - port 3 bit 4 is general pin one and the count input of timer 0.
// - port 3 bit 5 is general pin two and the count input of timer 1.
// - code comes from otp, calibration from eeprom, and sram holds only run-time variables.
`timescale 1ns/1ps

module csfr_top
    import csfr_pkg::*;
(
    input  wire logic         CLK_IN,             // core clock, 200 mhz
    input  wire logic         ARST_N_IN,          // async reset, active low
    input  wire logic [7:0]   ADDR_IN,            // sfr address
    input  wire logic [7:0]   WDATA_IN,           // write data
    input  wire logic         WR_IN,              // write strobe
    input  wire logic         RD_IN,              // read strobe
    output logic      [7:0]   RDATA_OUT,          // read data, cycle after strobe
    input  wire logic         OPC_VALID_IN,       // opcode present
    input  wire logic [7:0]   OPC_IN,             // opcode byte
    input  wire logic [7:0]   OPC_ARG_IN,         // byte after opcode
    output csfr_dec_t         DEC_OUT,            // decoded opcode fields
    input  wire csfr_memreq_t MEM_REQ_IN,         // memory access class
    output csfr_mem_t         MEM_SEL_OUT,        // selected memory
    input  wire logic         LIN_RX_IN,          // lin receive line
    input  wire logic         GENERAL_PIN_ONE_IN, // general pin one
    input  wire logic         GENERAL_PIN_TWO_IN, // general pin two
    input  wire logic         UART_RX_IN,         // uart receive
    input  wire logic [7:0]   P1_PIN_IN,          // port 1 pin levels
    output logic      [7:0]   P1_OUT,             // port 1 drive level
    output logic      [7:0]   P1_OE_OUT,          // port 1 drive enable
    output logic      [7:0]   OTP_SEC_OUT,        // port 0 security lines
    output logic              LS_A_OUT,           // low-side driver a
    output logic              LS_B_OUT,           // low-side driver b
    output logic              LIN_TX_OUT,         // lin transmit
    output logic              UART_TX_OUT,        // uart transmit
    output logic              WDOG_KICK_OUT,      // watchdog service pulse
    output logic              INT0_REQ_OUT,       // ext interrupt 0 flag
    output logic              INT1_REQ_OUT,       // ext interrupt 1 flag
    output logic              IRQ_OUT             // masked event interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [SY_W-1:0]  s1_q;
    logic [SY_W-1:0]  s2_q;
    logic [SY_W-1:0]  s3_q;
    logic [7:0]       p0_q;
    logic [7:0]       p1_q;
    logic [7:0]       p1_oe_q;
    logic [7:0]       p2_q;
    logic [7:0]       p3_q;
    logic [7:0]       plain_q [PL_N];
    logic [7:0]       timer_control_q;
    logic [7:0]       timer_control_d;
    logic [7:0]       tl_q [2];
    logic [7:0]       th_q [2];
    logic [1:0]       inc;
    logic [1:0]       tf_set;
    logic [1:0]       cnt_fall;
    logic [1:0]       int_n;
    logic [EV_W-1:0]  ev_q;
    logic [EV_W-1:0]  msk_q;
    logic [EV_W-1:0]  ev_set;
    logic             int0_fall;
    logic             int1_fall;
    logic             kick;
    logic             irq_q;
    logic             kick_q;
    logic [7:0]       rd_val;
    logic [7:0]       rdata_q;
    logic [7:0]       timer_mode;
    logic [7:0]       p3_rd;
    csfr_dec_t        dec_q;
    csfr_mem_t        msel_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; edges are taken from the second and third stage only

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            s1_q <= {SY_W{1'b1}};
            s2_q <= {SY_W{1'b1}};
            s3_q <= {SY_W{1'b1}};
        end else begin
            s1_q <= {P1_PIN_IN, UART_RX_IN, GENERAL_PIN_TWO_IN, GENERAL_PIN_ONE_IN, LIN_RX_IN};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign int_n[0]    = s2_q[SY_LIN];
    assign int_n[1]    = ~s2_q[SY_LIN];
    assign int0_fall   = s3_q[SY_LIN] & ~s2_q[SY_LIN];
    assign int1_fall   = ~s3_q[SY_LIN] & s2_q[SY_LIN];
    assign cnt_fall[0] = s3_q[SY_GP1] & ~s2_q[SY_GP1];
    assign cnt_fall[1] = s3_q[SY_GP2] & ~s2_q[SY_GP2];
    assign timer_mode        = plain_q[PL_TIMER_MODE];

    ////////////////////////////////////////////////////////////////////////////
    // port latches

    assign kick = WR_IN && ADDR_IN == A_P3 && WDATA_IN[P3_WDOG] != p3_q[P3_WDOG];

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            p0_q    <= RST_PORT;
            p1_q    <= RST_PORT;
            p1_oe_q <= 8'h00;
            p2_q    <= RST_PORT;
            p3_q    <= RST_PORT;
            kick_q  <= 1'b0;
        end else begin
            if (WR_IN && ADDR_IN == A_P0) begin
                p0_q <= WDATA_IN;
            end
            if (WR_IN && ADDR_IN == A_P1) begin
                p1_q    <= WDATA_IN;
                p1_oe_q <= ~WDATA_IN;                       // quasi pull: only a zero is driven
            end
            if (WR_IN && ADDR_IN == A_P2) begin
                p2_q <= WDATA_IN;
            end
            if (WR_IN && ADDR_IN == A_P3) begin
                p3_q <= WDATA_IN;
            end
            kick_q <= kick;
        end
    end

    assign OTP_SEC_OUT   = p0_q;
    assign P1_OUT        = p1_q;
    assign P1_OE_OUT     = p1_oe_q;
    assign LS_A_OUT      = p2_q[P2_LSA];
    assign LS_B_OUT      = p2_q[P2_LSB];
    assign LIN_TX_OUT    = p2_q[P2_LINTX];
    assign UART_TX_OUT   = p3_q[P3_UTX];
    assign WDOG_KICK_OUT = kick_q;

    ////////////////////////////////////////////////////////////////////////////
    // plain registers

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            for (int k = 0; k < PL_N; k++) begin
                plain_q[k] <= RST_SFR;
            end
        end else begin
            for (int k = 0; k < PL_N; k++) begin
                if (WR_IN && ADDR_IN == PLAIN_ADDR[k]) begin
                    plain_q[k] <= WDATA_IN;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timers; software writes win over a count in the same cycle

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            inc[i]    = timer_control_q[TC_TR[i]] && (!timer_mode[TM_GATE[i]] || int_n[i])
                        && (timer_mode[TM_CNT[i]] ? cnt_fall[i] : 1'b1);
            tf_set[i] = inc[i] && {th_q[i], tl_q[i]} == 16'hffff
                        && !(WR_IN && (ADDR_IN == TL_ADDR[i] || ADDR_IN == TH_ADDR[i]));
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            for (int i = 0; i < 2; i++) begin
                tl_q[i] <= RST_SFR;
                th_q[i] <= RST_SFR;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (WR_IN && ADDR_IN == TL_ADDR[i]) begin
                    tl_q[i] <= WDATA_IN;
                end else if (WR_IN && ADDR_IN == TH_ADDR[i]) begin
                    th_q[i] <= WDATA_IN;
                end else if (inc[i]) begin
                    {th_q[i], tl_q[i]} <= {th_q[i], tl_q[i]} + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer control; hardware sets win over a software clear

    always_comb begin
        timer_control_d = (WR_IN && ADDR_IN == A_TIMER_CONTROL) ? WDATA_IN : timer_control_q;
        for (int i = 0; i < 2; i++) begin
            if (tf_set[i]) begin
                timer_control_d[TC_TF[i]] = 1'b1;
            end
        end
        if (timer_control_q[TC_IT0]) begin
            timer_control_d[TC_IE0] = timer_control_d[TC_IE0] | int0_fall;
        end else begin
            timer_control_d[TC_IE0] = ~int_n[0];                     // level mode tracks the line
        end
        if (timer_control_q[TC_IT1]) begin
            timer_control_d[TC_IE1] = timer_control_d[TC_IE1] | int1_fall;
        end else begin
            timer_control_d[TC_IE1] = ~int_n[1];
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            timer_control_q <= RST_SFR;
        end else begin
            timer_control_q <= timer_control_d;
        end
    end

    assign INT0_REQ_OUT = timer_control_q[TC_IE0];
    assign INT1_REQ_OUT = timer_control_q[TC_IE1];

    ////////////////////////////////////////////////////////////////////////////
    // event status, write one to clear, mask, one level interrupt

    always_comb begin
        ev_set          = '0;
        ev_set[EV_INT0] = int0_fall;
        ev_set[EV_INT1] = int1_fall;
        ev_set[EV_TF0]  = tf_set[0];
        ev_set[EV_TF1]  = tf_set[1];
        ev_set[EV_WDOG] = kick;
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ev_q  <= '0;
            msk_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (WR_IN && ADDR_IN == A_EVST) begin
                ev_q <= (ev_q & ~WDATA_IN[EV_W-1:0]) | ev_set;
            end else begin
                ev_q <= ev_q | ev_set;
            end
            if (WR_IN && ADDR_IN == A_EVMSK) begin
                msk_q <= WDATA_IN[EV_W-1:0];
            end
            irq_q <= |(ev_q & msk_q);                       // lags the status by one cycle
        end
    end

    assign IRQ_OUT = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        p3_rd          = p3_q;
        p3_rd[P3_URX]  = s2_q[SY_URX];
        p3_rd[P3_INT0] = s2_q[SY_LIN];
        p3_rd[P3_INT1] = ~s2_q[SY_LIN];
        p3_rd[P3_T0]   = s2_q[SY_GP1];
        p3_rd[P3_T1]   = s2_q[SY_GP2];
    end

    always_comb begin
        rd_val = 8'h00;
        for (int k = 0; k < PL_N; k++) begin
            if (ADDR_IN == PLAIN_ADDR[k]) begin
                rd_val = plain_q[k];
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (ADDR_IN == TL_ADDR[i]) begin
                rd_val = tl_q[i];
            end
            if (ADDR_IN == TH_ADDR[i]) begin
                rd_val = th_q[i];
            end
        end
        if (ADDR_IN == A_P0) begin
            rd_val = p0_q;
        end
        if (ADDR_IN == A_P1) begin
            rd_val = s2_q[SY_P1LO +: 8];
        end
        if (ADDR_IN == A_P2) begin
            rd_val = p2_q;
        end
        if (ADDR_IN == A_P3) begin
            rd_val = p3_rd;
        end
        if (ADDR_IN == A_TIMER_CONTROL) begin
            rd_val = timer_control_q;
        end
        if (ADDR_IN == A_EVST) begin
            rd_val = {{(8-EV_W){1'b0}}, ev_q};
        end
        if (ADDR_IN == A_EVMSK) begin
            rd_val = {{(8-EV_W){1'b0}}, msk_q};
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= RD_IN ? rd_val : 8'h00;
        end
    end

    assign RDATA_OUT = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // opcode field decode

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            dec_q <= '0;
        end else begin
            dec_q.valid <= OPC_VALID_IN;
            if (OPC_VALID_IN) begin
                dec_q.reg_grp  <= OPC_IN[3];
                dec_q.reg_sel  <= OPC_IN[2:0];
                dec_q.is_abs   <= OPC_IN[4:0] == OPC_AJMP || OPC_IN[4:0] == OPC_ACALL;
                dec_q.is_call  <= OPC_IN[4:0] == OPC_ACALL;
                dec_q.abs_dest <= {OPC_IN[7:5], OPC_ARG_IN};
            end
        end
    end

    assign DEC_OUT = dec_q;

    ////////////////////////////////////////////////////////////////////////////
    // memory steering

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            msel_q <= MEM_NONE;
        end else if (MEM_REQ_IN.valid) begin
            unique case (MEM_REQ_IN.kind)
                ACC_FETCH: msel_q <= MEM_OTP;
                ACC_CALIB: msel_q <= MEM_EEPROM;
                ACC_VAR:   msel_q <= MEM_SRAM;
                default:   msel_q <= MEM_NONE;              // code 3 is not a class
            endcase
        end else begin
            msel_q <= MEM_NONE;
        end
    end

    assign MEM_SEL_OUT = msel_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    a_reg_sel_low: assert property (OPC_VALID_IN |=> DEC_OUT.reg_sel == $past(OPC_IN[2:0]))
        else $error("register select not from opcode low bits");

    a_abs_dest_hi: assert property (OPC_VALID_IN && OPC_IN[4:0] == OPC_ACALL
        |=> DEC_OUT.is_abs && DEC_OUT.is_call && DEC_OUT.abs_dest[10:8] == $past(OPC_IN[7:5]))
        else $error("absolute call destination high bits wrong");

    a_port_readback: assert property (RD_IN && ADDR_IN == A_P2 |=> RDATA_OUT == $past(p2_q))
        else $error("port 2 read does not return latch");

    a_lin_int0_edge: assert property (timer_control_q[TC_IT0] && $fell(s2_q[SY_LIN])
        |=> INT0_REQ_OUT)
        else $error("falling lin edge did not raise int0");

    a_lin_int1_edge: assert property (timer_control_q[TC_IT1] && $rose(s2_q[SY_LIN]) |=> INT1_REQ_OUT)
        else $error("rising lin edge did not raise int1");

    a_t0_count_pin: assert property (timer_control_q[TC_TR[0]] && timer_mode[TM_CNT[0]] && !timer_mode[TM_GATE[0]]
        && cnt_fall[0] && !WR_IN |=> {th_q[0], tl_q[0]} == $past({th_q[0], tl_q[0]}) + 16'h0001)
        else $error("timer 0 missed a pin one count");

    a_t1_hold_idle: assert property (timer_mode[TM_CNT[1]] && !cnt_fall[1] && !WR_IN
        |=> tl_q[1] == $past(tl_q[1]))
        else $error("timer 1 counted without a pin two edge");

    a_mem_fetch_otp: assert property (MEM_REQ_IN.valid && MEM_REQ_IN.kind == ACC_FETCH
        |=> MEM_SEL_OUT == MEM_OTP ##1 (MEM_SEL_OUT != MEM_OTP || $past(MEM_REQ_IN.valid)))
        else $error("code fetch not steered to otp");

    a_lin_tx_write: assert property (WR_IN && ADDR_IN == A_P2
        |=> LIN_TX_OUT == $past(WDATA_IN[P2_LINTX]) && LS_A_OUT == $past(WDATA_IN[P2_LSA]))
        else $error("port 2 write did not reach lin and driver a");

    a_wdog_kick: assert property (kick |=> WDOG_KICK_OUT ##1 ev_q[EV_WDOG])
        else $error("watchdog toggle gave no pulse or event");

    a_irq_level: assert property ((ev_q & msk_q) != '0 |=> IRQ_OUT)
        else $error("unmasked event did not raise interrupt");

endmodule : csfr_top

/* File: dv/csfr_top_bench.sv */
// self-checking random bench for the core sfr bank and port map
`timescale 1ns/1ps

module csfr_top_bench;
    import csfr_pkg::*;

    logic         clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, opc_v = 1'b0;
    logic         lin = 1'b1, gp1 = 1'b1, gp2 = 1'b1, urx = 1'b1;
    logic [7:0]   addr = 8'h00, wdata = 8'h00, opc = 8'h00, arg = 8'h00, p1_pin = 8'hff;
    logic [7:0]   rdata, p1_o, p1_oe, otp, d, v;
    logic         ls_a, ls_b, lin_tx, utx, kick, i0, i1, irq;
    csfr_memreq_t mreq = '0;
    csfr_dec_t    dec;
    csfr_mem_t    msel;
    int           num_errors = 0, checked = 0, n;
    logic [7:0]   ops [6] = '{8'he8, 8'hef, 8'h71, 8'he1, 8'h01, 8'hf1};

    always #2.5 clk = ~clk;

    csfr_top dut_u (.CLK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .OPC_VALID_IN(opc_v), .OPC_IN(opc), .OPC_ARG_IN(arg), .DEC_OUT(dec),
        .MEM_REQ_IN(mreq), .MEM_SEL_OUT(msel), .LIN_RX_IN(lin), .GENERAL_PIN_ONE_IN(gp1),
        .GENERAL_PIN_TWO_IN(gp2), .UART_RX_IN(urx), .P1_PIN_IN(p1_pin), .P1_OUT(p1_o), .P1_OE_OUT(p1_oe),
        .OTP_SEC_OUT(otp), .LS_A_OUT(ls_a), .LS_B_OUT(ls_b), .LIN_TX_OUT(lin_tx), .UART_TX_OUT(utx),
        .WDOG_KICK_OUT(kick), .INT0_REQ_OUT(i0), .INT1_REQ_OUT(i1), .IRQ_OUT(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= dat;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk

    function automatic csfr_mem_t mem_exp(input logic [1:0] k);
        return (k == 2'd0) ? MEM_OTP : (k == 2'd1) ? MEM_EEPROM : MEM_SRAM;
    endfunction : mem_exp

    task automatic count_kicks(input int exp);
        int c;
        c = 0;
        repeat (3) begin
            if (kick === 1'b1) c++;
            @(posedge clk); #1;
        end
        chk(c, exp);
    endtask : count_kicks

    task end_of_test;
        if (num_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(20000 * 5);
        num_errors++;
        end_of_test;
    end

    initial begin
        void'($urandom(22533));
        cyc(3);
        #1 chk({otp, p1_oe, ls_a, ls_b}, 18'h3fc03);
        cyc(3);
        arst_n <= 1'b1;
        rd_chk(A_P0, RST_PORT);
        rd_chk(A_P2, RST_PORT);
        rd_chk(A_TL0, RST_SFR);
        rd_chk(A_TIMER_CONTROL, 8'h08);
        foreach (PLAIN_ADDR[i]) begin
            rd_chk(PLAIN_ADDR[i], RST_SFR);
            d = $urandom;
            wr_reg(PLAIN_ADDR[i], d);
            rd_chk(PLAIN_ADDR[i], d);
        end
        wr_reg(8'h84, 8'hff);
        rd_chk(8'h84, 8'h00);
        // port outputs follow their latches
        d = $urandom;
        wr_reg(A_P2, d);
        #1 chk({ls_a, ls_b, lin_tx}, {d[0], d[1], d[3]});
        d = $urandom;
        wr_reg(A_P0, d);
        #1 chk(otp, d);
        d = $urandom;
        wr_reg(A_P1, d);
        #1 chk({p1_o, p1_oe}, {d, ~d});
        v = $urandom;
        p1_pin <= v & d; // bits driven low by the latch read low on the wire
        cyc(4);
        rd_chk(A_P1, v & d);
        for (int k = 0; k < 6; k++) begin
            v = $urandom;
            v[0] = k[0];
            lin <= v[0]; gp1 <= v[1]; gp2 <= v[2]; urx <= v[3];
            cyc(4);
            rd_chk(A_P3, {2'b11, v[2], v[1], ~v[0], v[0], 1'b1, v[3]});
            chk({i0, i1}, {~v[0], v[0]});
        end
        lin <= 1'b1; gp1 <= 1'b1; gp2 <= 1'b1;
        // external count inputs, falling edges only
        for (int i = 0; i < 2; i++) begin
            wr_reg(A_TIMER_MODE, i ? 8'h40 : 8'h04);
            wr_reg(A_TIMER_CONTROL, i ? 8'h40 : 8'h10);
            n = 2 + $urandom % 5;
            repeat (n) begin
                gp1 <= (i != 0); gp2 <= (i == 0);
                cyc(3);
                gp1 <= 1'b1; gp2 <= 1'b1;
                cyc(3);
            end
            cyc(4);
            wr_reg(A_TIMER_CONTROL, 8'h00);
            rd_chk(TL_ADDR[i], n[7:0]);
        end
        // overflow event, masked then unmasked, then cleared
        wr_reg(A_EVST, 8'h1f);
        wr_reg(A_TIMER_MODE, 8'h00);
        wr_reg(A_TL0, 8'hfe);
        wr_reg(A_TH0, 8'hff);
        wr_reg(A_TIMER_CONTROL, 8'h10);
        cyc(4);
        wr_reg(A_TIMER_CONTROL, 8'h00);
        #1 chk(irq, 1'b0);
        rd_chk(A_EVST, 8'h04);
        wr_reg(A_EVMSK, 8'h04);
        cyc(2);
        #1 chk(irq, 1'b1);
        wr_reg(A_EVST, 8'h04);
        cyc(2);
        #1 chk(irq, 1'b0);
        // edge mode: second write clears the flag the level mode left behind
        wr_reg(A_TIMER_CONTROL, 8'h05);
        wr_reg(A_TIMER_CONTROL, 8'h05);
        #1 chk({i0, i1}, 2'b00);
        @(posedge clk);
        lin <= 1'b0;
        cyc(4);
        #1 chk({i0, i1}, 2'b10);
        @(posedge clk);
        lin <= 1'b1;
        cyc(4);
        #1 chk({i0, i1}, 2'b11);
        rd_chk(A_EVST, 8'h03);
        wr_reg(A_EVST, 8'h03);
        wr_reg(A_TIMER_CONTROL, 8'h00);
        // watchdog service needs bit 7 to toggle
        wr_reg(A_P3, 8'h7f);
        #1 count_kicks(1);
        chk(utx, 1'b1);
        wr_reg(A_P3, 8'h7d);
        #1 count_kicks(0);
        chk(utx, 1'b0);
        rd_chk(A_EVST, 8'h10);
        // opcode field decode, corner opcodes first
        for (int k = 0; k < 16; k++) begin
            d = (k < 6) ? ops[k] : 8'($urandom);
            v = $urandom;
            @(posedge clk);
            opc_v <= 1'b1; opc <= d; arg <= v;
            @(posedge clk);
            opc_v <= 1'b0;
            #1 chk({dec.valid, dec.reg_grp, dec.reg_sel, dec.is_abs}, {1'b1, d[3:0], d[3:0] == 4'h1});
            if (d[3:0] == 4'h1) chk({dec.is_call, dec.abs_dest}, {d[4], d[7:5], v});
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            mreq <= {1'b1, csfr_acc_t'(k[1:0])};
            @(posedge clk);
            mreq <= '0;
            #1 chk(msel, mem_exp(k[1:0]));
            @(posedge clk);
            #1 chk(msel, MEM_NONE);
        end
        cyc(2);
        end_of_test;
    end

endmodule : csfr_top_bench
